//--- timer_consts.svh
// Register offsets, field positions, reset values and counts of the timer.
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_RUN_CONTROL 3'h0
`define OFS_MODE_OUTPUT_CONTROL 3'h1
`define OFS_COUNT_LOW 3'h2
`define OFS_COUNT_HIGH 3'h3
`define OFS_COMPARE_A_LOW 3'h4
`define OFS_COMPARE_A_HIGH 3'h5

// ****************************************************************
// Field positions
// ****************************************************************
`define RUN_COUNTER_ON_BIT 3
`define RUN_COMPARE_P_MSB 2
`define RUN_COMPARE_P_LSB 0
`define MOC_MODE_MSB 7
`define MOC_MODE_LSB 6
`define MOC_FUNC_MSB 5
`define MOC_FUNC_LSB 4
`define MOC_INIT_LEVEL_BIT 3
`define MOC_INVERT_BIT 2
`define MOC_SWAP_BIT 1
`define MOC_CLEAR_SRC_BIT 0

// ****************************************************************
// Reset values, widths and shifts
// ****************************************************************
`define RUN_CONTROL_RESET 8'h00
`define MODE_OUTPUT_CONTROL_RESET 8'h00
`define COMPARE_A_RESET 10'h000
`define COUNT_RESET 10'h000
`define COUNT_WIDTH 10
`define COMPARE_P_SHIFT 7

`endif

//--- timer_pkg.sv
// Types shared by the timer control and count register block.
package timer_pkg;

   // Operating mode field encodings.
   typedef enum logic [1:0] {
      MODE_COMPARE = 2'b00,
      MODE_CAPTURE = 2'b01,
      MODE_PWM = 2'b10,
      MODE_TIMER = 2'b11
   } mode_t;

   // Output function field encodings, as used in compare mode.
   typedef enum logic [1:0] {
      FUNC_NONE = 2'b00,
      FUNC_LOW = 2'b01,
      FUNC_HIGH = 2'b10,
      FUNC_TOGGLE = 2'b11
   } func_t;

   // Register bus request.
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   // Whole state of the timer block.
   typedef struct packed {
      logic [7:0] run_ctrl;
      logic [7:0] mode_ctrl;
      logic [9:0] compare_a;
      logic [9:0] count;
      logic out_level;
      logic pulse_done;
      logic capture_prev;
      logic [7:0] rdata;
      logic pin_out;
      logic pin_oe;
      logic match_a;
      logic match_p;
      logic capture_event;
   } state_t;

endpackage

//--- timer_control_and_count_regs.sv
// Mode, output control, counter and compare A registers of a 10-bit timer.
`timescale 1ns/100ps
`include "timer_consts.svh"

module timer_control_and_count_regs
   import timer_pkg::*;
(
   input wire logic CLOCK, // System clock, 100 MHz.
   input wire logic RSTN, // Asynchronous reset, active low.
   input wire logic TIMER_TICK, // One-cycle timer clock enable.
   input wire bus_req_t BUS_REQ, // Register address, data and strobes.
   output logic [7:0] RDATA, // Read data, valid the cycle after a read.
   input wire logic CAPTURE_IN, // Capture input pin level.
   output logic TIMER_OUT, // Timer output pin level.
   output logic TIMER_OUT_EN, // High while the block drives the pin.
   output logic MATCH_A, // One-cycle pulse on a comparator A match.
   output logic MATCH_P, // One-cycle pulse on a P match; none when compare or timer mode clears on A.
   output logic CAPTURE_EVENT // One-cycle pulse when a capture is taken.
);

   state_t q;
   state_t d;

   // ****************************************************************
   // Decoded fields
   // ****************************************************************
   mode_t mode;
   func_t func;
   logic counter_on;
   logic [2:0] compare_p;
   logic init_level;
   logic invert;
   logic swap;
   logic clear_src;
   logic [10:0] count_inc;
   logic [9:0] p_limit;
   logic hit_a;
   logic hit_p;
   logic overflow;
   logic clear_now;
   logic [9:0] duty;
   logic pwm_active;
   logic period_end;
   logic cap_rise;
   logic cap_fall;
   logic cap_take;
   logic on_rise;
   logic level;
   logic p_shown;
   logic [9:0] next_count;
   logic next_out_level;
   logic next_pulse_done;
   logic [9:0] next_compare_a;
   logic [7:0] read_word;
   logic pin_drive;
   logic pin_level;

   assign mode = mode_t'(q.mode_ctrl[`MOC_MODE_MSB:`MOC_MODE_LSB]);
   assign func = func_t'(q.mode_ctrl[`MOC_FUNC_MSB:`MOC_FUNC_LSB]);
   assign counter_on = q.run_ctrl[`RUN_COUNTER_ON_BIT];
   assign compare_p = q.run_ctrl[`RUN_COMPARE_P_MSB:`RUN_COMPARE_P_LSB];
   assign init_level = q.mode_ctrl[`MOC_INIT_LEVEL_BIT];
   assign invert = q.mode_ctrl[`MOC_INVERT_BIT];
   assign swap = q.mode_ctrl[`MOC_SWAP_BIT];
   assign clear_src = q.mode_ctrl[`MOC_CLEAR_SRC_BIT];

   // ****************************************************************
   // Comparators
   // ****************************************************************
   // Matches are taken on the count that the next tick would reach, so a
   // limit of N gives a period of exactly N ticks, counting 0 to N-1.
   assign count_inc = {1'b0, q.count} + 11'h001;
   assign p_limit = {compare_p, 7'h00};
   assign overflow = count_inc[`COUNT_WIDTH];
   assign hit_a = TIMER_TICK && counter_on
      && (count_inc[9:0] == q.compare_a);
   assign hit_p = TIMER_TICK && counter_on && (compare_p != 3'h0)
      && (count_inc[9:0] == p_limit);
   assign on_rise = BUS_REQ.wr && (BUS_REQ.addr == `OFS_RUN_CONTROL)
      && BUS_REQ.wdata[`RUN_COUNTER_ON_BIT] && !counter_on;

   // Counter clear source per mode.
   always_comb
   begin
      clear_now = 1'b0;
      case (mode)
         MODE_PWM:
         begin
            // The swap bit picks the period comparator; clear source ignored.
            if (swap)
               clear_now = hit_a;
            else
               clear_now = hit_p || (compare_p == 3'h0 && overflow);
         end
         MODE_CAPTURE:
            clear_now = hit_p || (compare_p == 3'h0 && overflow);
         default:
         begin
            if (clear_src)
               clear_now = hit_a;
            else
               clear_now = hit_p || (compare_p == 3'h0 && overflow);
         end
      endcase
   end

   assign period_end = TIMER_TICK && counter_on
      && (clear_now || overflow);

   // ****************************************************************
   // PWM duty
   // ****************************************************************
   // With swap set, a zero compare P value stands for the full 1024-tick duty.
   always_comb
   begin
      if (swap)
         duty = p_limit;
      else
         duty = q.compare_a;
   end
   assign pwm_active = (swap && compare_p == 3'h0) || (q.count < duty);

   // ****************************************************************
   // Capture edges
   // ****************************************************************
   assign cap_rise = CAPTURE_IN && !q.capture_prev;
   assign cap_fall = !CAPTURE_IN && q.capture_prev;
   always_comb
   begin
      case (func)
         FUNC_NONE: cap_take = cap_rise;
         FUNC_LOW: cap_take = cap_fall;
         FUNC_HIGH: cap_take = cap_rise || cap_fall;
         default: cap_take = 1'b0;
      endcase
      if (mode != MODE_CAPTURE || !counter_on)
         cap_take = 1'b0;
   end

   // ****************************************************************
   // Output pin level before inversion
   // ****************************************************************
   // The initial level bit names the active level; 1 means active high.
   always_comb
   begin
      level = 1'b0;
      case (func)
         FUNC_NONE: level = !init_level;
         FUNC_LOW: level = init_level;
         FUNC_HIGH: level = pwm_active ? init_level : !init_level;
         default:
            level = (pwm_active && !q.pulse_done) ? init_level
               : !init_level;
      endcase
   end

   // ****************************************************************
   // Counter
   // ****************************************************************
   // Only the counter-on rising edge lets software touch the count; a
   // falling edge merely stops the ticks and leaves the residue standing.
   always_comb
   begin
      next_count = q.count;
      if (TIMER_TICK && counter_on)
      begin
         if (clear_now)
            next_count = `COUNT_RESET;
         else
            next_count = count_inc[9:0];
      end
      if (on_rise)
         next_count = `COUNT_RESET;
   end

   // ****************************************************************
   // Match pulses
   // ****************************************************************
   // Clearing on A in compare or timer mode hides the P match, since the
   // period is then set by comparator A alone.
   assign p_shown = hit_p && !(clear_src
      && (mode == MODE_COMPARE || mode == MODE_TIMER));

   // ****************************************************************
   // Compare output latch
   // ****************************************************************
   // Set and clear requests equal to the current level simply leave it
   // standing, so a request matching the initial level shows nothing.
   always_comb
   begin
      next_out_level = q.out_level;
      if (hit_a && mode == MODE_COMPARE)
      begin
         case (func)
            FUNC_LOW: next_out_level = 1'b0;
            FUNC_HIGH: next_out_level = 1'b1;
            FUNC_TOGGLE: next_out_level = !q.out_level;
            default: next_out_level = q.out_level;
         endcase
      end
      if (on_rise)
         next_out_level = init_level;
   end

   // ****************************************************************
   // Single pulse
   // ****************************************************************
   // The pulse is rearmed only by a fresh start, so a stop and restart
   // always give exactly one more pulse.
   always_comb
   begin
      next_pulse_done = q.pulse_done;
      if (period_end)
         next_pulse_done = 1'b1;
      if (on_rise)
         next_pulse_done = 1'b0;
   end

   // ****************************************************************
   // Compare A value
   // ****************************************************************
   // A capture beats a software write to compare A in the same cycle.
   always_comb
   begin
      next_compare_a = q.compare_a;
      if (BUS_REQ.wr && BUS_REQ.addr == `OFS_COMPARE_A_LOW)
         next_compare_a[7:0] = BUS_REQ.wdata;
      if (BUS_REQ.wr && BUS_REQ.addr == `OFS_COMPARE_A_HIGH)
         next_compare_a[9:8] = BUS_REQ.wdata[1:0];
      if (cap_take)
         next_compare_a = q.count;
   end

   // ****************************************************************
   // Read back
   // ****************************************************************
   always_comb
   begin
      read_word = 8'h00;
      case (BUS_REQ.addr)
         `OFS_RUN_CONTROL: read_word = q.run_ctrl;
         `OFS_MODE_OUTPUT_CONTROL: read_word = q.mode_ctrl;
         `OFS_COUNT_LOW: read_word = q.count[7:0];
         `OFS_COUNT_HIGH: read_word = {6'h00, q.count[9:8]};
         `OFS_COMPARE_A_LOW: read_word = q.compare_a[7:0];
         `OFS_COMPARE_A_HIGH: read_word = {6'h00, q.compare_a[9:8]};
         default: read_word = 8'h00;
      endcase
   end

   // ****************************************************************
   // Pin drive
   // ****************************************************************
   // Timer and capture modes release the pin and show it low, so neither
   // the initial level nor the invert bit can reach it there.
   always_comb
   begin
      pin_drive = 1'b0;
      pin_level = 1'b0;
      case (mode)
         MODE_COMPARE:
         begin
            pin_drive = 1'b1;
            pin_level = q.out_level ^ invert;
         end
         MODE_PWM:
         begin
            pin_drive = 1'b1;
            pin_level = level ^ invert;
         end
         default:
         begin
            pin_drive = 1'b0;
            pin_level = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      d = q;
      d.match_a = hit_a;
      d.match_p = p_shown;
      d.capture_event = cap_take;
      d.capture_prev = CAPTURE_IN;
      d.count = next_count;
      d.out_level = next_out_level;
      d.pulse_done = next_pulse_done;
      d.compare_a = next_compare_a;
      // Control writes land at the next edge; counter bytes ignore writes.
      if (BUS_REQ.wr && BUS_REQ.addr == `OFS_RUN_CONTROL)
         d.run_ctrl = BUS_REQ.wdata;
      if (BUS_REQ.wr && BUS_REQ.addr == `OFS_MODE_OUTPUT_CONTROL)
         d.mode_ctrl = BUS_REQ.wdata;
      // Read data stand for exactly one cycle after the read strobe.
      d.rdata = BUS_REQ.rd ? read_word : 8'h00;
      d.pin_oe = pin_drive;
      d.pin_out = pin_level;
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         q <= '0;
         q.run_ctrl <= `RUN_CONTROL_RESET;
         q.mode_ctrl <= `MODE_OUTPUT_CONTROL_RESET;
         q.compare_a <= `COMPARE_A_RESET;
         q.count <= `COUNT_RESET;
      end
      else
         q <= d;
   end

   assign RDATA = q.rdata;
   assign TIMER_OUT = q.pin_out;
   assign TIMER_OUT_EN = q.pin_oe;
   assign MATCH_A = q.match_a;
   assign MATCH_P = q.match_p;
   assign CAPTURE_EVENT = q.capture_event;

endmodule

//--- pin_load.sv
// Load on the timer output pin and source of the capture line.
`timescale 1ns/100ps
module pin_load
(
   input wire logic clk, // System clock.
   input wire logic level, // Capture level asked by the bench.
   input wire logic out, // Pin level from the block.
   input wire logic out_en, // Block drives the pin.
   output logic cap, // Capture line to the block.
   output logic pin // Resolved pin level.
);
   // A pull-down holds the released pin low, so a stale level never shows.
   assign pin = out_en ? out : 1'b0;
   always_ff @(posedge clk)
   begin
      cap <= level;
   end
endmodule

//--- timer_checker.sv
// Concurrent checks on the ports of the timer register block.
`timescale 1ns/100ps
module timer_checker
   import timer_pkg::*;
(
   input wire logic CLOCK, // Clock.
   input wire logic RSTN, // Reset, active low.
   input wire logic TIMER_TICK, // Timer clock enable.
   input wire bus_req_t BUS_REQ, // Register request.
   input wire logic [7:0] RDATA, // Read data.
   input wire logic CAPTURE_IN, // Capture line.
   input wire logic TIMER_OUT, // Pin level.
   input wire logic TIMER_OUT_EN, // Pin enable.
   input wire logic MATCH_A, // A match pulse.
   input wire logic MATCH_P, // P match pulse.
   input wire logic CAPTURE_EVENT // Capture pulse.
);
   logic [7:0] ctl_q;
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
         ctl_q <= 8'h00;
      else if (BUS_REQ.wr && BUS_REQ.addr == 3'h1)
         ctl_q <= BUS_REQ.wdata;
   end
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RSTN);
   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_rdata_idle: assert property (!BUS_REQ.rd |=> RDATA == 8'h00)
      else $error("read data not zero when idle");
   a_count_high_zero: assert property
      (BUS_REQ.rd && BUS_REQ.addr == 3'h3 |=> RDATA[7:2] == 6'h00)
      else $error("count high byte upper bits set");
   a_cmpa_high_zero: assert property
      (BUS_REQ.rd && BUS_REQ.addr == 3'h5 |=> RDATA[7:2] == 6'h00)
      else $error("compare high byte upper bits set");
   a_match_on_tick: assert property (MATCH_A |-> $past(TIMER_TICK))
      else $error("match without a timer tick");
   a_capture_rise: assert property
      (ctl_q[7:4] == 4'h4 && CAPTURE_EVENT |->
       $past(CAPTURE_IN) && !$past(CAPTURE_IN, 2))
      else $error("capture without a rising edge");
   a_capture_off: assert property
      ((ctl_q[7:4] == 4'h7) [*3] |-> !CAPTURE_EVENT)
      else $error("capture while disabled");
   a_mode_no_capture: assert property
      ((ctl_q[7:6] != 2'b01) [*3] |-> !CAPTURE_EVENT)
      else $error("capture outside capture mode");
   a_timer_no_drive: assert property
      ((ctl_q[7:6] == 2'b11) [*3] |-> !TIMER_OUT_EN && !TIMER_OUT)
      else $error("pin driven in timer mode");
   a_compare_drives: assert property
      ((ctl_q[7:6] == 2'b00) [*4] |-> TIMER_OUT_EN)
      else $error("pin not driven in compare mode");
   a_no_match_p: assert property
      ((ctl_q[7:6] == 2'b00 && ctl_q[0]) [*2] |-> !MATCH_P)
      else $error("P match while clearing on A");
endmodule
bind timer_control_and_count_regs timer_checker i_timer_checker (
   .CLOCK(CLOCK), .RSTN(RSTN), .TIMER_TICK(TIMER_TICK), .BUS_REQ(BUS_REQ),
   .RDATA(RDATA), .CAPTURE_IN(CAPTURE_IN), .TIMER_OUT(TIMER_OUT),
   .TIMER_OUT_EN(TIMER_OUT_EN), .MATCH_A(MATCH_A), .MATCH_P(MATCH_P),
   .CAPTURE_EVENT(CAPTURE_EVENT));

//--- tb_top.sv
// Self-checking bench for the timer register block.
`timescale 1ns/100ps
module tb_top
   import timer_pkg::*;
;
   logic clock;
   logic rstn = 1'b0;
   logic tick = 1'b0;
   logic level = 1'b0;
   bus_req_t req = '0;
   logic [7:0] rdata;
   logic tout, tout_en, cap_ev, cap, pin;
   int failures = 0, check_count = 0, events = 0, n0, f;
   timer_control_and_count_regs i_timer_control_and_count_regs (
      .CLOCK(clock), .RSTN(rstn), .TIMER_TICK(tick), .BUS_REQ(req),
      .RDATA(rdata), .CAPTURE_IN(cap), .TIMER_OUT(tout),
      .TIMER_OUT_EN(tout_en), .MATCH_A(), .MATCH_P(), .CAPTURE_EVENT(cap_ev));
   pin_load i_pin_load (.clk(clock), .level(level), .out(tout),
      .out_en(tout_en), .cap(cap), .pin(pin));
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(negedge clock)
   begin
      if (cap_ev === 1'b1)
         events++;
   end
   task end_sim;
      if (failures == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      req.wr <= 1'b0;
   endtask
   task rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clock);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      req.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task ticks(input int n);
      @(posedge clock);
      tick <= 1'b1;
      repeat (n) @(posedge clock);
      tick <= 1'b0;
   endtask
   task pinchk(input logic e);
      repeat (3) @(posedge clock);
      #1 chk({7'h00, pin}, {7'h00, e});
   endtask
   // Control changes only while stopped, then a fresh start from zero.
   task setup(input logic [7:0] ctl, input logic [2:0] p);
      wr(3'h0, 8'h00);
      wr(3'h1, ctl);
      wr(3'h0, {5'b00001, p});
   endtask
   // ****************************************************************
   // Tests
   // ****************************************************************
   initial
   begin
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      for (f = 1; f < 6; f++)
         rd(f[2:0], 8'h00);
      wr(3'h4, 8'ha5);
      rd(3'h4, 8'ha5);
      wr(3'h5, 8'hff);
      rd(3'h5, 8'h03);
      wr(3'h2, 8'hff);
      rd(3'h2, 8'h00);
      wr(3'h4, 8'h05);
      wr(3'h5, 8'h00);
      for (f = 0; f < 4; f++)
      begin
         setup({2'b00, f[1:0], 4'h1}, 3'h0);
         pinchk(1'b0);
         ticks(5);
         pinchk(f > 1);
         rd(3'h2, 8'h00);
      end
      setup(8'h35, 3'h0);
      pinchk(1'b1);
      ticks(3);
      rd(3'h2, 8'h03);
      wr(3'h0, 8'h00);
      ticks(2);
      rd(3'h2, 8'h03);
      setup(8'h00, 3'h0);
      ticks(300);
      rd(3'h2, 8'h2c);
      rd(3'h3, 8'h01);
      ticks(726);
      rd(3'h2, 8'h02);
      setup(8'h00, 3'h1);
      ticks(130);
      rd(3'h2, 8'h02);
      wr(3'h5, 8'h01);
      setup(8'h01, 3'h1);
      ticks(200);
      rd(3'h2, 8'hc8);
      wr(3'h5, 8'h00);
      for (f = 0; f < 4; f++)
      begin
         setup({2'b10, f[1:0], 4'h9}, 3'h1);
         ticks(2);
         pinchk(f != 0);
         ticks(128);
         pinchk(f == 1 || f == 2);
         rd(3'h2, 8'h02);
      end
      setup(8'ha4, 3'h1);
      ticks(2);
      pinchk(1'b1);
      for (f = 0; f < 4; f++)
      begin
         setup({2'b01, f[1:0], 4'h0}, 3'h0);
         n0 = events;
         @(posedge clock);
         level <= 1'b1;
         repeat (4) @(posedge clock);
         level <= 1'b0;
         repeat (4) @(posedge clock);
         #1 chk(8'(events - n0), (f == 2) ? 8'h02 : 8'((f < 2) ? 1 : 0));
      end
      rd(3'h4, 8'h00);
      setup(8'hc8, 3'h0);
      pinchk(1'b0);
      end_sim;
   end
   initial
   begin
      #200000;
      failures++;
      end_sim;
   end
endmodule
